// ==== rfc_consts.svh ====
`ifndef RFC_CONSTS_SVH
`define RFC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte addresses (lower byte of each pair; reserved ranges by first and last byte)
// ----------------------------------------------------------------------
`define RFC_A_ENDUR      6'h00
`define RFC_A_RATE       6'h04
`define RFC_A_OFF        6'h14
`define RFC_A_GAIN       6'h16
`define RFC_A_RSV1_LO    6'h18
`define RFC_A_RSV1_HI    6'h1F
`define RFC_A_ALM1_MAG   6'h20
`define RFC_A_ALM2_MAG   6'h22
`define RFC_A_ALM1_PRD   6'h24
`define RFC_A_ALM2_PRD   6'h26
`define RFC_A_ALM_CTL    6'h28
`define RFC_A_RSV2_LO    6'h2A
`define RFC_A_RSV2_HI    6'h2F
`define RFC_A_DAC        6'h30
`define RFC_A_PIN        6'h32
`define RFC_A_MISC       6'h34
`define RFC_A_SMPL       6'h36
`define RFC_A_SENS       6'h38
`define RFC_A_SLP        6'h3A
`define RFC_A_STAT       6'h3C
`define RFC_A_CMD        6'h3E

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define RFC_RST_ZERO     16'h0000
`define RFC_RST_GAIN     16'h0800
`define RFC_RST_SMPL     16'h0001
`define RFC_RST_SENS     16'h0402
`define RFC_ERASED       16'hFFFF
`define RFC_OFF_MSB      13
`define RFC_GAIN_MSB     11
`define RFC_GAIN_SHIFT   11
`define RFC_ND_BIT       15
`define RFC_STAT_BUSY    0
`define RFC_CMD_NULL     0
`define RFC_CMD_FACT     1
`define RFC_CMD_DAC      2
`define RFC_CMD_SAVE     3
`define RFC_CMD_SRST     7
`define RFC_OP_WRITE     2'h2
`define RFC_OP_READ      2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RFC_CLK_MHZ      200
`define RFC_SAVE_MS      50
`define RFC_SAVE_CYC     (`RFC_SAVE_MS * `RFC_CLK_MHZ * 1000)

`endif

// ==== rfc_pkg.sv ====
`default_nettype none

package rfc_pkg;

    typedef logic [15:0] rfc_word_t;
    typedef logic [4:0]  rfc_idx_t;

    typedef enum logic [3:0]
    {
        RFC_LOAD = 4'h1,
        RFC_IDLE = 4'h2,
        RFC_SAVE = 4'h4,
        RFC_WAIT = 4'h8
    } rfc_state_t;

endpackage : rfc_pkg

`default_nettype wire

// ==== rfc_mem_if.sv ====
`default_nettype none

interface rfc_mem_if;
    import rfc_pkg::*;

    rfc_idx_t  addr;
    logic      we;
    rfc_word_t wdata;
    rfc_word_t rdata;

    modport ctrl (output addr, output we, output wdata, input rdata);
    modport mem  (input addr, input we, input wdata, output rdata);
endinterface : rfc_mem_if

`default_nettype wire

// ==== rfc_nvmem.sv ====
`include "rfc_consts.svh"
`default_nettype none

module rfc_nvmem
    import rfc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic ce,
    rfc_mem_if.mem    m
);
    // The array has no reset: it stands for storage that survives reset.
    // It starts erased so that the loader can tell an unwritten word.
    rfc_word_t cells [0:31] = '{default: `RFC_ERASED};

    always_ff @(posedge mclk)
    begin
        if (ce)
        begin
            if (m.we)
                cells[m.addr] <= m.wdata;
            m.rdata <= cells[m.addr];
        end
    end
endmodule : rfc_nvmem

`default_nettype wire

// ==== rfc_regbank.sv ====
// Contract
// - Control registers live in volatile flops; writes act from there.
// - After reset the saved image is loaded from flash automatically.
// - Each nonvolatile register owns one flash word with its last save.
// - Flash is written only on the save, autonull and factory restore commands, never on a write.
// - A 16-bit flash write counter is kept and readable.
// - Misc control: whole word saved, only upper byte restored, lower volatile.
// - Converter data, pin control, sleep count, status have no flash copy.
// - Calibrated rate equals raw sample times gain plus offset.
// - Factory defaults, autonull, factory restore and manual values supported.
// - Offset is 14-bit two's complement in low bits, top bits ignored.
// - Gain is 12-bit unsigned in low bits, top four bits ignored.
// - Gain default 0x0800 means exactly unity.
// - Decode map pairs, reserved unused, status read-only, command write-only.
// - Each byte has its own address; either returns the whole word.
// - Write frame: one, zero, six address bits, eight data bits.
// - Save runs about 50 ms and holds the device busy until done.
`include "rfc_consts.svh"
`default_nettype none

module rfc_regbank
    import rfc_pkg::*;
#(
    parameter int unsigned SAVE_CYCLES = `RFC_SAVE_CYC
)
(
    input  wire logic        mclk,
    input  wire logic        ce,
    input  wire logic        nrst,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe,
    input  wire logic [13:0] raw_rate,
    input  wire logic        raw_valid,
    output logic      [13:0] rate_out,
    output logic             rate_valid,
    output logic      [15:0] dac_out,
    output logic             busy
);
    localparam rfc_idx_t I_END  = 5'(`RFC_A_ENDUR >> 1);
    localparam rfc_idx_t I_RATE = 5'(`RFC_A_RATE >> 1);
    localparam rfc_idx_t I_OFF  = 5'(`RFC_A_OFF >> 1);
    localparam rfc_idx_t I_GAIN = 5'(`RFC_A_GAIN >> 1);
    localparam rfc_idx_t I_A1M  = 5'(`RFC_A_ALM1_MAG >> 1);
    localparam rfc_idx_t I_ACTL = 5'(`RFC_A_ALM_CTL >> 1);
    localparam rfc_idx_t I_DAC  = 5'(`RFC_A_DAC >> 1);
    localparam rfc_idx_t I_PIN  = 5'(`RFC_A_PIN >> 1);
    localparam rfc_idx_t I_MISC = 5'(`RFC_A_MISC >> 1);
    localparam rfc_idx_t I_SMPL = 5'(`RFC_A_SMPL >> 1);
    localparam rfc_idx_t I_SENS = 5'(`RFC_A_SENS >> 1);
    localparam rfc_idx_t I_SLP  = 5'(`RFC_A_SLP >> 1);
    localparam rfc_idx_t I_STAT = 5'(`RFC_A_STAT >> 1);
    localparam rfc_idx_t I_CMD  = 5'(`RFC_A_CMD >> 1);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // flash-backed set
    function automatic logic is_nv(input rfc_idx_t i);
        is_nv = (i == I_OFF) || (i == I_GAIN) || (i == I_MISC)
             || (i == I_SMPL) || (i == I_SENS)
             || ((i >= I_A1M) && (i <= I_ACTL));
    endfunction : is_nv

    function automatic logic is_rw(input rfc_idx_t i);
        is_rw = is_nv(i) || (i == I_DAC) || (i == I_PIN) || (i == I_SLP);
    endfunction : is_rw

    function automatic rfc_word_t rst_val(input rfc_idx_t i);
        case (i)
            I_GAIN:  rst_val = `RFC_RST_GAIN;
            I_SMPL:  rst_val = `RFC_RST_SMPL;
            I_SENS:  rst_val = `RFC_RST_SENS;
            default: rst_val = `RFC_RST_ZERO;
        endcase
    endfunction : rst_val

    // Result saturates to 14 bits so a large gain cannot wrap the sign.
    function automatic logic [13:0] cal(input logic [13:0] x,
                                        input logic [11:0] m,
                                        input logic [13:0] b);
        logic signed [26:0] p;
        logic signed [15:0] s;
        p = $signed(x) * $signed({1'b0, m});
        s = 16'(p >>> `RFC_GAIN_SHIFT) + $signed({{2{b[13]}}, b});
        if (s > 16'sh1FFF)
            cal = 14'h1FFF;
        else if (s < -16'sh2000)
            cal = 14'h2000;
        else
            cal = s[13:0];
    endfunction : cal

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    rfc_state_t  state;
    rfc_word_t   ctl [0:31];
    rfc_word_t   endur;
    logic [5:0]  cnt;
    logic [31:0] wait_cnt;
    logic        save_pend;
    logic        srst;
    logic [13:0] rate_q;
    logic        nd;
    logic        sclk_q;
    logic        cs_q;
    logic [3:0]  bitcnt;
    logic [15:0] sh_in;
    logic [15:0] sh_out;
    rfc_word_t   rd_shadow;

    rfc_mem_if fl ();

    rfc_nvmem u_nvmem
    (
        .mclk (mclk),
        .ce   (ce),
        .m    (fl.mem)
    );

    // ------------------------------------------------------------------
    // Serial frame decode
    // ------------------------------------------------------------------
    wire logic        rst_all   = !nrst || srst;
    wire logic        rise      = !cs_n && sclk && !sclk_q;
    wire logic        fall      = !cs_n && !sclk && sclk_q;
    wire logic        start     = !cs_n && cs_q;
    wire logic        done      = rise && (bitcnt == 4'hF);
    wire logic [15:0] frame     = {sh_in[14:0], din};
    wire logic        is_wr     = done && (frame[15:14] == `RFC_OP_WRITE);
    wire logic        is_rd     = done && (frame[15:14] == `RFC_OP_READ);
    wire rfc_idx_t    f_idx     = frame[13:9];
    wire logic        f_hi      = frame[8];
    wire logic [7:0]  f_dat     = frame[7:0];
    wire logic        idle      = (state == RFC_IDLE);
    wire logic        wr_ok     = is_wr && idle && is_rw(f_idx);
    wire logic        cmd_wr    = is_wr && idle && (f_idx == I_CMD) && !f_hi;
    wire logic        c_null    = cmd_wr && f_dat[`RFC_CMD_NULL];
    wire logic        c_fact    = cmd_wr && f_dat[`RFC_CMD_FACT];
    wire logic        c_dac     = cmd_wr && f_dat[`RFC_CMD_DAC];
    wire logic        c_save    = cmd_wr && f_dat[`RFC_CMD_SAVE];
    wire logic        c_srst    = cmd_wr && f_dat[`RFC_CMD_SRST];
    wire rfc_word_t   stat_word = 16'(busy) << `RFC_STAT_BUSY;
    wire rfc_word_t   rate_word = {nd, 1'b0, rate_q};
    wire logic [13:0] off14     = ctl[I_OFF][`RFC_OFF_MSB:0];
    wire logic [11:0] gain12    = ctl[I_GAIN][`RFC_GAIN_MSB:0];
    wire logic [13:0] cal_now   = cal(raw_rate, gain12, off14);
    wire rfc_idx_t    ld_idx    = 5'(cnt - 6'h01);
    wire logic        ld_hit    = (state == RFC_LOAD) && (cnt != 6'h00);
    wire logic        ld_fresh  = fl.rdata != `RFC_ERASED;
    wire logic [13:0] null_off  = 14'(~rate_q + 14'h0001);

    wire rfc_word_t rd_word =
        (f_idx == I_END)  ? endur     :
        (f_idx == I_RATE) ? rate_word :
        (f_idx == I_STAT) ? stat_word :
        is_rw(f_idx)      ? ctl[f_idx] : `RFC_RST_ZERO;

    assign busy     = !idle;
    assign dout     = sh_out[15];
    assign dout_oe  = !cs_n;
    assign rate_out = rate_q;

    // ------------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst_all)
        begin
            sclk_q    <= 1'b1;
            cs_q      <= 1'b1;
            bitcnt    <= 4'h0;
            sh_in     <= 16'h0000;
            sh_out    <= 16'h0000;
            rd_shadow <= 16'h0000;
        end
        else if (ce)
        begin
            sclk_q <= sclk;
            cs_q   <= cs_n;
            if (start)
            begin
                bitcnt <= 4'h0;
                sh_out <= rd_shadow;
            end
            else if (fall && (bitcnt != 4'h0))
                sh_out <= {sh_out[14:0], 1'b0};
            if (rise)
            begin
                bitcnt <= bitcnt + 4'h1;
                sh_in  <= frame;
            end
            if (is_rd)
                rd_shadow <= rd_word;
        end
    end

    // ------------------------------------------------------------------
    // Flash sequencer
    // ------------------------------------------------------------------
    assign fl.addr  = cnt[4:0];
    assign fl.we    = (state == RFC_SAVE) && (is_nv(cnt[4:0]) || cnt == 6'h00);
    assign fl.wdata = (cnt == 6'h00) ? 16'(endur + 16'h0001) : ctl[cnt[4:0]];

    always_ff @(posedge mclk)
    begin
        if (rst_all)
        begin
            state     <= RFC_LOAD;
            cnt       <= 6'h00;
            wait_cnt  <= 32'h0;
            save_pend <= 1'b0;
            srst      <= 1'b0;
        end
        else if (ce)
        begin
            srst <= c_srst;
            case (state)
                RFC_LOAD:
                begin
                    cnt <= cnt + 6'h01;
                    if (cnt == 6'h20)
                        state <= RFC_IDLE;
                end
                RFC_IDLE:
                begin
                    cnt <= 6'h00;
                    if (save_pend)
                    begin
                        save_pend <= 1'b0;
                        state     <= RFC_SAVE;
                    end
                end
                RFC_SAVE:
                begin
                    cnt      <= cnt + 6'h01;
                    wait_cnt <= 32'h0;
                    if (cnt == 6'h1F)
                        state <= RFC_WAIT;
                end
                // hold busy for the save time
                RFC_WAIT:
                begin
                    wait_cnt <= wait_cnt + 32'h1;
                    if (wait_cnt >= SAVE_CYCLES - 1)
                        state <= RFC_IDLE;
                end
                default:
                    state <= RFC_LOAD;
            endcase
            // A new request wins over the clear taken in idle.
            if (c_save || c_null || c_fact)
                save_pend <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst_all)
        begin
            for (int i = 0; i < 32; i++)
                ctl[i] <= rst_val(5'(i));
            endur   <= 16'h0000;
            dac_out <= 16'h0000;
        end
        else if (ce)
        begin
            if (ld_hit && ld_fresh && ld_idx == I_END)
                endur <= fl.rdata;
            if (ld_hit && ld_fresh && ld_idx == I_MISC)
                ctl[I_MISC][15:8] <= fl.rdata[15:8];
            else if (ld_hit && ld_fresh && is_nv(ld_idx))
                ctl[ld_idx] <= fl.rdata;
            if (state == RFC_SAVE && cnt == 6'h1F)
                endur <= endur + 16'h0001;
            if (wr_ok && f_hi)
                ctl[f_idx][15:8] <= f_dat;
            else if (wr_ok)
                ctl[f_idx][7:0] <= f_dat;
            if (c_fact)
            begin
                ctl[I_OFF]  <= `RFC_RST_ZERO;
                ctl[I_GAIN] <= `RFC_RST_GAIN;
            end
            else if (c_null)
                ctl[I_OFF] <= {2'b00, null_off};
            if (c_dac)
                dac_out <= ctl[I_DAC];
        end
    end

    // ------------------------------------------------------------------
    // Calibrated rate path
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst_all)
        begin
            rate_q     <= 14'h0000;
            nd         <= 1'b0;
            rate_valid <= 1'b0;
        end
        else if (ce)
        begin
            rate_valid <= raw_valid;
            // y = m * x + b, new sample wins over read clear
            if (raw_valid)
            begin
                rate_q <= cal_now;
                nd     <= 1'b1;
            end
            else if (is_rd && f_idx == I_RATE)
                nd <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence save_walk_s;
        (state == RFC_SAVE) ##1 (state == RFC_WAIT);
    endsequence

    sequence held_busy_s;
        busy [*8];
    endsequence

    cal_apply_a: assert property (@(posedge mclk) disable iff (rst_all)
        raw_valid && ce |=> rate_out == cal($past(raw_rate),
            $past(gain12), $past(off14)))
        else $error("rate output does not match calibration");

    unity_gain_a: assert property (@(posedge mclk) disable iff (rst_all)
        raw_valid && ce && gain12 == 12'h800 && off14 == 14'h0000
        |=> rate_out == $past(raw_rate))
        else $error("default gain is not unity");

    load_start_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(nrst) |-> state == RFC_LOAD ##33 state != RFC_LOAD)
        else $error("start-up load not run");

    // a register write never starts a save
    lazy_save_a: assert property (@(posedge mclk) disable iff (rst_all)
        wr_ok && ce |=> !save_pend && !fl.we)
        else $error("register write started a flash save");

    endur_step_a: assert property (@(posedge mclk) disable iff (rst_all)
        save_walk_s |-> endur == $past(endur) + 16'h0001)
        else $error("write counter did not step");

    vol_keep_a: assert property (@(posedge mclk) disable iff (rst_all)
        ld_hit && ce |=> $stable(ctl[I_DAC]) && $stable(ctl[I_SLP])
            && $stable(ctl[I_PIN]) && $stable(ctl[I_MISC][7:0]))
        else $error("volatile register changed by load");

    save_hold_a: assert property (@(posedge mclk) disable iff (rst_all)
        save_walk_s |-> held_busy_s)
        else $error("busy dropped during flash save");

    // reserved and command read as zero
    rsv_zero_a: assert property (@(posedge mclk) disable iff (rst_all)
        is_rd && ce && !is_rw(f_idx) && f_idx != I_END && f_idx != I_RATE
            && f_idx != I_STAT |=> rd_shadow == 16'h0000)
        else $error("unmapped address read nonzero");

    // write frame lands in the addressed byte
    wr_byte_a: assert property (@(posedge mclk) disable iff (rst_all)
        wr_ok && ce && f_hi && f_idx == I_SLP |=> ctl[I_SLP][15:8] == $past(f_dat))
        else $error("write frame not stored");

endmodule : rfc_regbank

`default_nettype wire

// ==== rfc_host.sv ====
`default_nettype none

module rfc_host
    import rfc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic dout,
    input  wire logic dout_oe,
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    timeunit 1ns;
    timeprecision 100ps;

    logic hold;
    logic miso;

    // A released output shows the inverse of its last bit, so a read
    // that lands outside the driven window cannot pass by luck.
    assign miso = dout_oe ? dout : ~hold;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din  = 1'b0;
        hold = 1'b0;
    end

    always @(posedge mclk)
        if (dout_oe)
            hold <= dout;

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        step(1);
        cs_n = 1'b0;
        step(2);
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 1'b0;
            din  = tx[i];
            step(3);
            rx[i] = miso;
            sclk  = 1'b1;
            step(3);
        end
        cs_n = 1'b1;
        step(3);
    endtask : xfer
endmodule : rfc_host

`default_nettype wire

// ==== tb.sv ====
`include "rfc_consts.svh"
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("mismatch %s exp %h got %h", nm, e, g); \
        end \
    end

module tb
    import rfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SAVE_N = 400;
    localparam int LIMIT  = 60000;

    logic        mclk, ce, nrst, cs_n, sclk, din, dout, dout_oe;
    logic        raw_valid, rate_valid, busy;
    logic [13:0] raw_rate, rate_out, last_rate;
    logic [15:0] dac_out, lfsr, r;
    rfc_word_t   rx, off, gain, dw;
    int          bad_count, check_count, cyc;
    logic [5:0]  ta [6] = '{`RFC_A_OFF, `RFC_A_GAIN | 6'h01, `RFC_A_SMPL,
                            `RFC_A_SENS, `RFC_A_ENDUR, `RFC_A_CMD};
    rfc_word_t   te [6] = '{16'h0000, 16'h0800, 16'h0001, 16'h0402,
                            16'h0000, 16'h0000};

    rfc_regbank #(.SAVE_CYCLES(SAVE_N)) u_dut (
        .mclk(mclk), .ce(ce), .nrst(nrst), .cs_n(cs_n), .sclk(sclk),
        .din(din), .dout(dout), .dout_oe(dout_oe), .raw_rate(raw_rate),
        .raw_valid(raw_valid), .rate_out(rate_out),
        .rate_valid(rate_valid), .dac_out(dac_out), .busy(busy));

    rfc_host u_host (.mclk(mclk), .dout(dout), .dout_oe(dout_oe),
        .cs_n(cs_n), .sclk(sclk), .din(din));

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd

    function automatic logic [13:0] exp_rate(input logic [13:0] x,
                                             input rfc_word_t g,
                                             input rfc_word_t o);
        int v;
        int p;
        v = $signed(x);
        p = (v * int'(g[11:0])) >>> 11;
        v = $signed(o[13:0]);
        p = p + v;
        if (p > 8191) p = 8191;
        if (p < -8192) p = -8192;
        return p[13:0];
    endfunction : exp_rate

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] t;
        u_host.xfer({`RFC_OP_WRITE, a, d}, t);
    endtask : wr

    task automatic wrw(input logic [5:0] a, input rfc_word_t w);
        wr(a, w[7:0]);
        wr(a | 6'h01, w[15:8]);
    endtask : wrw

    task automatic rd(input logic [5:0] a, output rfc_word_t w);
        logic [15:0] t;
        u_host.xfer({`RFC_OP_READ, a, 8'h00}, t);
        u_host.xfer(16'h0000, w);
    endtask : rd

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            u_host.step(1);
            n++;
        end
        `CHK("busy_end", 1'b0, busy)
        `CHK("dout_oe", 1'b0, dout_oe)
    endtask : wait_idle

    task automatic sample(input logic [13:0] x);
        int n;
        u_host.step(1);
        raw_rate  = x;
        raw_valid = 1'b1;
        u_host.step(1);
        raw_valid = 1'b0;
        n = 0;
        while (rate_valid !== 1'b1 && n < 4)
        begin
            u_host.step(1);
            n++;
        end
        last_rate = exp_rate(x, gain, off);
        `CHK("rate", last_rate, rate_out)
        `CHK("rate_valid", 1'b1, rate_valid)
    endtask : sample

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            $display("mismatch cycles exp below %0d got %0d", LIMIT, cyc);
            test_done();
        end
    end

    initial
    begin
        ce = 1'b1;
        nrst = 1'b0;
        raw_rate = 14'h0000;
        raw_valid = 1'b0;
        lfsr = 16'h0036;
        off = 16'h0000;
        gain = 16'h0800;
        repeat (16) @(posedge mclk);
        #1;
        `CHK("busy_rst", 1'b1, busy)
        nrst = 1'b1;
        wait_idle();
        for (int i = 0; i < 6; i++)
        begin
            rd(ta[i], rx);
            `CHK("reset_val", te[i], rx)
        end
        r = rnd();
        sample(r[13:0]);
        $display("test reset done");

        for (int k = 0; k < 6; k++)
        begin
            off = rnd();
            gain = rnd();
            if (k == 0) {off, gain} = {16'hDFFF, 16'hFFFF};
            if (k == 1) {off, gain} = {16'h2000, 16'h0FFF};
            wrw(`RFC_A_OFF, off);
            wrw(`RFC_A_GAIN, gain);
            rd(`RFC_A_OFF | 6'h01, rx);
            `CHK("off", off[13:0], rx[13:0])
            rd(`RFC_A_GAIN, rx);
            `CHK("gain", gain[11:0], rx[11:0])
            r = rnd();
            if (k == 0) r = 16'h1FFF;
            if (k == 1) r = 16'h2000;
            sample(r[13:0]);
            r = rnd();
            sample(r[13:0]);
        end
        $display("test calibration done");

        wr(6'h18, 8'h5A);
        wr(6'h2B, 8'hA5);
        wr(`RFC_A_STAT, 8'hFF);
        rd(6'h18, rx);
        `CHK("rsv1", 16'h0000, rx)
        rd(6'h2A, rx);
        `CHK("rsv2", 16'h0000, rx)
        rd(`RFC_A_STAT, rx);
        `CHK("status", 16'h0000, rx)
        $display("test reserved done");

        wrw(`RFC_A_MISC, 16'h5AA5);
        wrw(`RFC_A_SLP, 16'h0033);
        rd(`RFC_A_ENDUR, rx);
        `CHK("endur0", 16'h0000, rx)
        wr(`RFC_A_CMD, 8'h08);
        `CHK("busy_save", 1'b1, busy)
        wr(`RFC_A_OFF, ~off[7:0]);
        wait_idle();
        rd(`RFC_A_OFF, rx);
        `CHK("off_busy", off[13:0], rx[13:0])
        rd(`RFC_A_ENDUR, rx);
        `CHK("endur1", 16'h0001, rx)
        wrw(`RFC_A_OFF, off ^ 16'h0123);
        wr(`RFC_A_CMD, 8'h80);
        wait_idle();
        rd(`RFC_A_OFF, rx);
        `CHK("off_load", off[13:0], rx[13:0])
        rd(`RFC_A_GAIN, rx);
        `CHK("gain_load", gain[11:0], rx[11:0])
        rd(`RFC_A_MISC, rx);
        `CHK("misc_load", 16'h5A00, rx)
        rd(`RFC_A_SLP, rx);
        `CHK("sleep_load", 16'h0000, rx)
        rd(`RFC_A_ENDUR, rx);
        `CHK("endur_load", 16'h0001, rx)
        $display("test flash done");

        dw = rnd();
        wrw(`RFC_A_DAC, dw);
        wr(`RFC_A_CMD, 8'h04);
        `CHK("dac", dw, dac_out)
        r = rnd();
        sample(r[13:0]);
        wr(`RFC_A_CMD, 8'h01);
        wait_idle();
        off = {2'b00, -last_rate};
        rd(`RFC_A_OFF, rx);
        `CHK("autonull", off, rx)
        wr(`RFC_A_CMD, 8'h02);
        wait_idle();
        off = 16'h0000;
        gain = 16'h0800;
        rd(`RFC_A_OFF, rx);
        `CHK("fact_off", off, rx)
        rd(`RFC_A_GAIN, rx);
        `CHK("fact_gain", gain, rx)
        rd(`RFC_A_ENDUR, rx);
        `CHK("endur3", 16'h0003, rx)
        r = rnd();
        sample(r[13:0]);
        $display("test commands done");
        test_done();
    end
endmodule : tb

`default_nettype wire
